//--- rtl/dpmc_core.sv
// Power-mode control of the address decoder array
`timescale 1ns/1ps
// Functional notes
// - Bit 0 of power_saving_control is the full-speed disable bit.
// - power_saving_control answers at offset 10h of io_register_space.
// - Reset clears the register to zero, so the array runs at full speed.
// - With the bit at one, the array idles in standby while inputs hold.
// - In low-power mode any input change wakes, evaluates, latches, sleeps.
// - Low-power outputs come 10 ns later, 20 ns on low-voltage parts.
// - The bit touches only the decoder array, never memory behaviour.
// - After a change the array stays awake 25 ns, catching later changes.
// - On low-voltage parts changes under 50 ns apart are one activity.
// - half_array_saver is fixed at configuration, not by bus writes.
// - half_array_saver stretches memory access by 10 ns, 20 ns on LV parts.
module dpmc_core #(
    parameter int N_IN = 16,
    parameter int N_OUT = 8,
    parameter bit LOW_VOLTAGE = 1'b0
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire dpmc_pkg::dpmc_bus_s bus,
    output logic [7:0] rdata,
    input wire logic [N_IN-1:0] pad_in,
    input wire logic [N_OUT-1:0] pad_eval,
    output logic [N_OUT-1:0] pad_out,
    output logic array_active,
    input wire logic half_array_saver_cfg,
    output logic [dpmc_pkg::CNT_W-1:0] mem_stretch
);
    localparam logic [dpmc_pkg::CNT_W-1:0] LAT_CYC = LOW_VOLTAGE ?
        dpmc_pkg::CNT_W'(dpmc_pkg::LAT_LV_CYC) :
        dpmc_pkg::CNT_W'(dpmc_pkg::LAT_STD_CYC);
    localparam logic [dpmc_pkg::CNT_W-1:0] WIN_CYC = LOW_VOLTAGE ?
        dpmc_pkg::CNT_W'(dpmc_pkg::WIN_LV_CYC) :
        dpmc_pkg::CNT_W'(dpmc_pkg::WIN_STD_CYC);
    localparam logic [dpmc_pkg::CNT_W-1:0] MEM_CYC = LOW_VOLTAGE ?
        dpmc_pkg::CNT_W'(dpmc_pkg::MEM_LV_CYC) :
        dpmc_pkg::CNT_W'(dpmc_pkg::MEM_STD_CYC);
    localparam logic [dpmc_pkg::CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [dpmc_pkg::CNT_W-1:0] CNT_ONE = 5'h01;

    logic [7:0] psc;
    logic [N_IN-1:0] pad_prev;
    logic half_array_saver;
    dpmc_pkg::dpmc_state_e state;
    dpmc_pkg::dpmc_state_e next_state;
    logic [dpmc_pkg::CNT_W-1:0] win_cnt;
    logic [dpmc_pkg::CNT_W-1:0] lat_cnt;
    logic [dpmc_pkg::CNT_W-1:0] next_win_cnt;
    logic [dpmc_pkg::CNT_W-1:0] next_lat_cnt;

    ////////////////////////////////////////////////////////////////////////
    // Register decode
    wire hit = bus.addr == dpmc_pkg::PSC_OFFSET;
    wire wr_hit = bus.wr && hit;
    wire rd_hit = bus.rd && hit;
    wire full_speed_off = psc[dpmc_pkg::FSD_BIT];
    wire edge_seen = pad_in != pad_prev;
    wire [7:0] next_rdata = rd_hit ? psc : 8'h00;

    // Whole byte is stored; upper bits stay reserved and are not decoded
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            psc <= dpmc_pkg::PSC_RESET;
        end else if (wr_hit) begin
            psc <= bus.wdata;
        end
    end

    // Read data is registered and reads zero off the mapped offset
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Half-array saver strap, caught while reset is held
    // Bus writes never reach it, so it cannot change during operation
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            half_array_saver <= half_array_saver_cfg;
        end
    end

    // Memory stretch depends on the strap only, not on the power bit
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mem_stretch <= CNT_ZERO;
        end else begin
            mem_stretch <= half_array_saver ? MEM_CYC : CNT_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power state and counters
    always_comb begin
        next_state = state;
        next_win_cnt = win_cnt;
        next_lat_cnt = lat_cnt;
        case (state)
            dpmc_pkg::DPMC_FULL: begin
                if (full_speed_off) begin
                    next_state = dpmc_pkg::DPMC_STANDBY;
                end
            end
            dpmc_pkg::DPMC_STANDBY: begin
                if (!full_speed_off) begin
                    next_state = dpmc_pkg::DPMC_FULL;
                end else if (edge_seen) begin
                    next_state = dpmc_pkg::DPMC_ACTIVE;
                    next_win_cnt = WIN_CYC;
                    next_lat_cnt = LAT_CYC;
                end
            end
            dpmc_pkg::DPMC_ACTIVE: begin
                // A change inside the window extends it, no new wake-up
                if (!full_speed_off) begin
                    next_state = dpmc_pkg::DPMC_FULL;
                end else if (edge_seen) begin
                    next_win_cnt = WIN_CYC;
                    next_lat_cnt = LAT_CYC;
                end else begin
                    if (win_cnt != CNT_ZERO) begin
                        next_win_cnt = win_cnt - CNT_ONE;
                    end
                    if (lat_cnt != CNT_ZERO) begin
                        next_lat_cnt = lat_cnt - CNT_ONE;
                    end
                    if (win_cnt <= CNT_ONE && lat_cnt <= CNT_ONE) begin
                        next_state = dpmc_pkg::DPMC_STANDBY;
                    end
                end
            end
            default: begin
                next_state = dpmc_pkg::DPMC_FULL;
            end
        endcase
    end

    // Latch strobe when the added delay runs out
    wire lat_done = state == dpmc_pkg::DPMC_ACTIVE && !edge_seen &&
        lat_cnt == CNT_ONE;
    wire full_mode = state == dpmc_pkg::DPMC_FULL;
    wire [N_OUT-1:0] next_pad_out = (full_mode || lat_done) ?
        pad_eval : pad_out;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= dpmc_pkg::DPMC_FULL;
            win_cnt <= CNT_ZERO;
            lat_cnt <= CNT_ZERO;
            pad_prev <= '0;
        end else begin
            state <= next_state;
            win_cnt <= next_win_cnt;
            lat_cnt <= next_lat_cnt;
            pad_prev <= pad_in;
        end
    end

    // Outputs held between wake-ups so standby keeps them stable
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pad_out <= '0;
            array_active <= 1'b1;
        end else begin
            pad_out <= next_pad_out;
            array_active <= next_state != dpmc_pkg::DPMC_STANDBY;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_wake;
        state == dpmc_pkg::DPMC_STANDBY && full_speed_off && edge_seen;
    endsequence

    property p_reset_val;
        @(posedge sys_clk) $fell(rst) |-> psc == dpmc_pkg::PSC_RESET &&
            state == dpmc_pkg::DPMC_FULL;
    endproperty
    a_reset_val: assert property (p_reset_val) else $error("bad reset");

    property p_readback;
        @(posedge sys_clk) disable iff (rst)
        wr_hit ##1 !wr_hit ##1 (rd_hit && !wr_hit) |=>
            rdata == $past(bus.wdata, 3);
    endproperty
    a_readback: assert property (p_readback) else $error("readback");

    property p_offset;
        @(posedge sys_clk) disable iff (rst)
        bus.wr && bus.addr != dpmc_pkg::PSC_OFFSET |=> $stable(psc);
    endproperty
    a_offset: assert property (p_offset) else $error("off-map write");

    property p_to_standby;
        @(posedge sys_clk) disable iff (rst)
        wr_hit && bus.wdata[dpmc_pkg::FSD_BIT] && full_mode |=>
            ##1 state == dpmc_pkg::DPMC_STANDBY;
    endproperty
    a_to_standby: assert property (p_to_standby) else $error("no sb");

    property p_idle;
        @(posedge sys_clk) disable iff (rst)
        state == dpmc_pkg::DPMC_STANDBY && full_speed_off && !edge_seen
            |=> !array_active && $stable(pad_out);
    endproperty
    a_idle: assert property (p_idle) else $error("woke idle");

    property p_wake;
        @(posedge sys_clk) disable iff (rst)
        s_wake |=> array_active;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake");

    property p_latency;
        @(posedge sys_clk) disable iff (rst)
        s_wake ##1 (!edge_seen && full_speed_off)[*2] |=>
            $stable(pad_out);
    endproperty
    a_latency: assert property (p_latency) else $error("early out");

    property p_window;
        @(posedge sys_clk) disable iff (rst)
        s_wake ##1 (full_speed_off)[*7] |-> array_active;
    endproperty
    a_window: assert property (p_window) else $error("short win");

    property p_mem;
        @(posedge sys_clk) disable iff (rst)
        wr_hit ##1 1'b1 |=> mem_stretch == $past(mem_stretch);
    endproperty
    a_mem: assert property (p_mem) else $error("memory moved");

    property p_strap;
        @(posedge sys_clk) disable iff (rst) 1'b1 |=> $stable(half_array_saver);
    endproperty
    a_strap: assert property (p_strap) else $error("strap moved");
endmodule : dpmc_core

//--- rtl/dpmc_pkg.sv
// Constants and types for the decoder power-mode control block
package dpmc_pkg;
    // Register map
    localparam logic [7:0] PSC_OFFSET = 8'h10;
    localparam logic [7:0] PSC_RESET = 8'h00;
    localparam int FSD_BIT = 0;

    // Clock period and documented times, all in ns
    localparam int CLK_PERIOD_NS = 4;
    localparam int LAT_STD_NS = 10;
    localparam int LAT_LV_NS = 20;
    localparam int WIN_STD_NS = 25;
    localparam int WIN_LV_NS = 50;
    localparam int MEM_STD_NS = 10;
    localparam int MEM_LV_NS = 20;

    // Least times round up to whole cycles
    localparam int LAT_STD_CYC = (LAT_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LAT_LV_CYC = (LAT_LV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WIN_STD_CYC = (WIN_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WIN_LV_CYC = (WIN_LV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MEM_STD_CYC = (MEM_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MEM_LV_CYC = (MEM_LV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int CNT_W = 5;

    // Decoder array power state
    typedef enum logic [1:0] {
        DPMC_FULL,
        DPMC_STANDBY,
        DPMC_ACTIVE
    } dpmc_state_e;

    // Register access from the host bus
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } dpmc_bus_s;
endpackage : dpmc_pkg

//--- testbench/dpmc_host.sv
// Host bus model that writes and reads the power saving control register
`timescale 1ns/1ps
module dpmc_host (
    input wire logic sys_clk,
    output dpmc_pkg::dpmc_bus_s bus,
    input wire logic [7:0] rdata
);
    // Bus starts idle
    initial begin
        bus = '0;
    end
    ////////////////////////////////////////////////////////////////////////
    // One write; reserved bits always go out as ones
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: d | 8'hfe, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        // Released lines flip so a stale value is never mistaken for data
        bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask : write
    // One read; data is registered, so it is taken just after the read edge
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus <= '{addr: ~a, wdata: 8'hff, wr: 1'b0, rd: 1'b0};
        #1;
        d = rdata;
    endtask : read
endmodule : dpmc_host

//--- testbench/testbench.sv
// Self-checking bench for the decoder power-mode control block
`timescale 1ns/1ps
module testbench;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic cfg = 1'b0;
    logic [15:0] pad_in = 16'h0000;
    logic [7:0] pad_eval = 8'h00;
    dpmc_pkg::dpmc_bus_s bus;
    logic [7:0] rdata;
    logic [7:0] pad_out;
    logic array_active;
    logic [dpmc_pkg::CNT_W-1:0] mem_stretch;
    int miscompares = 0;
    int comparisons = 0;
    int n;
    // 250 MHz clock
    always #2 sys_clk = ~sys_clk;
    dpmc_core u_dut (.sys_clk(sys_clk), .rst(rst), .bus(bus), .rdata(rdata),
        .pad_in(pad_in), .pad_eval(pad_eval), .pad_out(pad_out),
        .array_active(array_active), .half_array_saver_cfg(cfg),
        .mem_stretch(mem_stretch));
    dpmc_host u_host (.sys_clk(sys_clk), .bus(bus), .rdata(rdata));
    ////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic complete_run();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_host.read(a, d);
        chk(d, exp);
    endtask : rd_chk
    // Counts cycles until pad_out or array_active shows exp; bounded
    task automatic wait_for(input bit act, input logic [7:0] exp);
        while ((act ? {7'h00, array_active} : pad_out) !== exp) begin
            @(posedge sys_clk);
            #1;
            n++;
            if (n > 60) begin
                miscompares++;
                complete_run();
            end
        end
    endtask : wait_for
    task automatic do_reset(input logic strap);
        @(posedge sys_clk);
        rst <= 1'b1;
        cfg <= strap;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        cfg <= ~strap;
        #1;
    endtask : do_reset
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rd_chk(8'h10, 8'h00);
        chk({7'h00, array_active}, 8'h01);
        chk({3'h0, mem_stretch}, 8'h00);
        u_host.write(8'h10, 8'h00);
        rd_chk(8'h10, 8'hfe);
        u_host.write(8'h10, 8'h01);
        rd_chk(8'h10, 8'hff);
        u_host.write(8'h11, 8'h00);
        rd_chk(8'h11, 8'h00);
        rd_chk(8'h10, 8'hff);
        u_host.write(8'h10, 8'h00);
        $display("test regs done");
    endtask : t_regs
    // Full speed: result passes after one cycle
    task automatic t_full();
        @(posedge sys_clk);
        pad_eval <= 8'h5a;
        n = 0;
        wait_for(1'b0, 8'h5a);
        chk(8'(n), 8'h01);
        $display("test full speed done");
    endtask : t_full
    // Low power: standby holds, a change wakes, a second one restarts
    task automatic t_low();
        u_host.write(8'h10, 8'h01);
        n = 0;
        wait_for(1'b1, 8'h00);
        @(posedge sys_clk);
        pad_eval <= 8'ha5;
        repeat (4) @(posedge sys_clk);
        #1;
        chk(pad_out, 8'h5a);
        chk({7'h00, array_active}, 8'h00);
        // First change wakes; the second lands just before the latch
        @(posedge sys_clk);
        pad_in <= 16'h0001;
        repeat (3) @(posedge sys_clk);
        pad_in <= 16'h8001;
        pad_eval <= 8'h3c;
        n = 0;
        wait_for(1'b0, 8'h3c);
        chk(8'(n), 8'(dpmc_pkg::LAT_STD_CYC + 1));
        wait_for(1'b1, 8'h00);
        chk(8'(n), 8'(dpmc_pkg::WIN_STD_CYC + 1));
        chk({3'h0, mem_stretch}, 8'h00);
        $display("test low power done");
    endtask : t_low
    // Strap fixed at reset; bus writes leave it alone
    task automatic t_strap();
        do_reset(1'b1);
        rd_chk(8'h10, 8'h00);
        chk({3'h0, mem_stretch}, 8'(dpmc_pkg::MEM_STD_CYC));
        u_host.write(8'h10, 8'h00);
        chk({3'h0, mem_stretch}, 8'(dpmc_pkg::MEM_STD_CYC));
        $display("test strap done");
    endtask : t_strap
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        do_reset(1'b0);
        t_regs();
        t_full();
        t_low();
        t_strap();
        complete_run();
    end
endmodule : testbench
